// ===== hpc_pkg.sv
// Purpose: shared constants and types for the hall pwm signal conditioner
// Assumes: 20 MHz system clock, 11-bit pwm resolution
// Notes:   register indices are the command-port addresses
package hpc_pkg;
    localparam int ADC_W    = 14;
    localparam int GAIN_W   = 14;
    localparam int GAIN_FRC = 11;
    localparam int QD_W     = 11;
    localparam int FLOOR_W  = 10;
    localparam int CEIL_W   = 11;
    localparam int MODE_W   = 6;
    localparam int TC_W     = 6;
    localparam int QUADRATIC_TEMP_COEFF_W   = 5;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 16;
    localparam int DUTY_W   = 12;
    localparam int SUM_W    = ADC_W + GAIN_W - GAIN_FRC + 2;
    localparam int ACC_W    = ADC_W + 8;
    // mode register fields
    localparam int RNG_LSB  = 0;
    localparam int FLT_LSB  = 3;
    localparam int FLD_W    = 3;
    // register indices
    localparam logic [ADDR_W-1:0] IX_MODE  = 4'h0;
    localparam logic [ADDR_W-1:0] IX_GAIN  = 4'h1;
    localparam logic [ADDR_W-1:0] IX_QD    = 4'h2;
    localparam logic [ADDR_W-1:0] IX_FLOOR = 4'h3;
    localparam logic [ADDR_W-1:0] IX_CEIL  = 4'h4;
    localparam logic [ADDR_W-1:0] IX_LOCK  = 4'h5;
    localparam logic [ADDR_W-1:0] IX_SAMP  = 4'h6;
    localparam logic [ADDR_W-1:0] IX_TC    = 4'h7;
    localparam logic [ADDR_W-1:0] IX_QUADRATIC_TEMP_COEFF  = 4'h8;
    localparam logic [ADDR_W-1:0] IX_TRIMO = 4'h9;
    localparam logic [ADDR_W-1:0] IX_TRIMA = 4'hA;
    // duty scale: full scale is 100 percent
    localparam logic [DUTY_W-1:0] DUTY_FULL = 12'h800;
    // filter sample limits, per corner code
    localparam logic [ADC_W-1:0] LIM_80   = 14'hF80;
    localparam logic [ADC_W-1:0] LIM_160  = 14'h7C1;
    localparam logic [ADC_W-1:0] LIM_500  = 14'h14AC;
    localparam logic [ADC_W-1:0] LIM_1K   = 14'hA56;
    localparam logic [ADC_W-1:0] LIM_2K   = 14'h5E8;
    // positive sample ceilings, per corner code
    localparam logic [ADC_W-1:0] LIMH_80  = 14'hF7F;
    localparam logic [ADC_W-1:0] LIMH_160 = 14'h7C1;
    localparam logic [ADC_W-1:0] LIMH_500 = 14'h14AA;
    localparam logic [ADC_W-1:0] LIMH_1K  = 14'hA55;
    localparam logic [ADC_W-1:0] LIMH_2K  = 14'h5E7;
    // filter shift per corner code
    localparam logic [3:0] SH_80  = 4'h7;
    localparam logic [3:0] SH_160 = 4'h6;
    localparam logic [3:0] SH_500 = 4'h5;
    localparam logic [3:0] SH_1K  = 4'h4;
    localparam logic [3:0] SH_2K  = 4'h3;
    // pwm timing
    localparam int CLK_HZ    = 20_000_000;
    localparam int PWM_HZ    = 125;
    localparam int PWM_STEPS = 2048;
    localparam int PWM_DIV   = CLK_HZ / (PWM_HZ * PWM_STEPS);
    typedef enum logic [1:0] {
        HPC_LOAD,
        HPC_RUN,
        HPC_PROG
    } hpc_state_t;
endpackage

// ===== hpc_conditioner.sv
// Purpose: digital signal chain of a programmable linear field sensor
// Assumes: telegram decoder and converter run on clk_sys
// Notes:   nonvolatile cells are not touched by rst
//
// How it works
// - duty equals gain times sample/2048 plus quiescent
// - multiply, add, limit, then pulse width
// - low mode bits pick field range
// - high mode bits pick filter corner
// - sample limits depend on filter corner
// - gain signed, minus four to four
// - unity gain: 2048 counts give 100 percent
// - quiescent duty signed, 1/1024 steps
// - negative quiescent lowers maximum duty
// - floor zero to fifty percent
// - ceiling zero to hundred percent
// - lock acts after power cycle, until nv_clear erases it
// - unlocked registers reprogrammable any number times
// - readable 14-bit filtered sample register
// - sample filtered before readout
// - north pole positive, south negative
// - commands over supply, answered on output
// - pwm suspended during programming
// - trim registers read only
// - temperature coefficients drive sensitivity scaling
`timescale 1ns/100ps
module hpc_conditioner #(
    parameter logic [hpc_pkg::DATA_W-1:0] TRIM_OSC = 16'h0055, // arbitrary
    parameter logic [hpc_pkg::DATA_W-1:0] TRIM_ADC = 16'h00AA, // arbitrary
    parameter int                         PWM_DIV  = hpc_pkg::PWM_DIV
) (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    // production erase of nonvolatile cells
    input  wire logic                          nv_clear,
    // converter sample, north positive
    input  wire logic                          adc_valid,
    input  wire logic signed [hpc_pkg::ADC_W-1:0] adc_sample,
    // supply modulation detected (pin level)
    input  wire logic                          prog_pin,
    // decoded telegram commands
    input  wire logic                          cmd_valid,
    input  wire logic                          cmd_write,
    input  wire logic [hpc_pkg::ADDR_W-1:0]    cmd_addr,
    input  wire logic [hpc_pkg::DATA_W-1:0]    cmd_wdata,
    // answer on output pin
    output logic                               rsp_valid,
    output logic [hpc_pkg::DATA_W-1:0]         rsp_data,
    // pwm output pin and programming busy flag
    output logic                               pwm_out,
    output logic                               prog_busy,
    // front end settings
    output logic [hpc_pkg::FLD_W-1:0]          fe_range_code,
    output logic [7:0]                         fe_range_mt,
    output logic [hpc_pkg::TC_W-1:0]           fe_tc_lin,
    output logic [hpc_pkg::QUADRATIC_TEMP_COEFF_W-1:0]         fe_tc_quad
);
    import hpc_pkg::*;

    initial begin
        if (PWM_DIV < 1 || PWM_DIV > 65536) $error("PWM_DIV out of range");
    end

    // nonvolatile cells and working copies
    logic [MODE_W-1:0]        nv_mode,  mode_q;
    logic signed [GAIN_W-1:0] nv_gain,  gain_q;
    logic signed [QD_W-1:0]   nv_qd,    qd_q;
    logic [FLOOR_W-1:0]       nv_floor, floor_q;
    logic [CEIL_W-1:0]        nv_ceil,  ceil_q;
    logic [TC_W-1:0]          nv_tc,    tc_q;
    logic [QUADRATIC_TEMP_COEFF_W-1:0]        nv_quadratic_temp_coeff,  quadratic_temp_coeff_q;
    logic                     nv_lock,  lock_act_q;
    hpc_state_t               state_q;
    logic                     prog_s1_q, prog_s2_q;
    logic                     wr_en;

    always_ff @(posedge clk_sys) begin
        prog_s1_q <= prog_pin;
        prog_s2_q <= prog_s1_q;
    end

    // locked part ignores every command
    assign wr_en = cmd_valid && cmd_write && !lock_act_q;

    // nonvolatile cells survive rst, lock only sets by command, cleared by nv_clear
    always_ff @(posedge clk_sys) begin
        if (nv_clear) begin
            nv_mode  <= '0;
            nv_gain  <= '0;
            nv_qd    <= '0;
            nv_floor <= '0;
            nv_ceil  <= '0;
            nv_tc    <= '0;
            nv_quadratic_temp_coeff  <= '0;
            nv_lock  <= 1'b0;
        end else if (wr_en) begin
            case (cmd_addr)
                IX_MODE:  nv_mode  <= cmd_wdata[MODE_W-1:0];
                IX_GAIN:  nv_gain  <= cmd_wdata[GAIN_W-1:0];
                IX_QD:    nv_qd    <= cmd_wdata[QD_W-1:0];
                IX_FLOOR: nv_floor <= cmd_wdata[FLOOR_W-1:0];
                IX_CEIL:  nv_ceil  <= cmd_wdata[CEIL_W-1:0];
                IX_TC:    nv_tc    <= cmd_wdata[TC_W-1:0];
                IX_QUADRATIC_TEMP_COEFF:  nv_quadratic_temp_coeff  <= cmd_wdata[QUADRATIC_TEMP_COEFF_W-1:0];
                IX_LOCK:  nv_lock  <= nv_lock | cmd_wdata[0];
                default:  ;
            endcase
        end
    end

    // working copy: loaded at power-up, follows writes after; the lock copy changes only at power-up
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_q     <= nv_mode;
            gain_q     <= nv_gain;
            qd_q       <= nv_qd;
            floor_q    <= nv_floor;
            ceil_q     <= nv_ceil;
            tc_q       <= nv_tc;
            quadratic_temp_coeff_q     <= nv_quadratic_temp_coeff;
            lock_act_q <= nv_lock;
        end else if (wr_en) begin
            case (cmd_addr)
                IX_MODE:  mode_q  <= cmd_wdata[MODE_W-1:0];
                IX_GAIN:  gain_q  <= cmd_wdata[GAIN_W-1:0];
                IX_QD:    qd_q    <= cmd_wdata[QD_W-1:0];
                IX_FLOOR: floor_q <= cmd_wdata[FLOOR_W-1:0];
                IX_CEIL:  ceil_q  <= cmd_wdata[CEIL_W-1:0];
                IX_TC:    tc_q    <= cmd_wdata[TC_W-1:0];
                IX_QUADRATIC_TEMP_COEFF:  quadratic_temp_coeff_q  <= cmd_wdata[QUADRATIC_TEMP_COEFF_W-1:0];
                default:  ;
            endcase
        end
    end

    // mode decode
    logic [FLD_W-1:0] rng_code, flt_code;
    logic [3:0]       flt_sh;
    logic [ADC_W-1:0] flt_lim, flt_lim_hi;
    assign rng_code = mode_q[RNG_LSB +: FLD_W];
    assign flt_code = mode_q[FLT_LSB +: FLD_W];

    always_comb begin
        case (flt_code)
            3'h0:    begin flt_sh = SH_80;  flt_lim = LIM_80;  end
            3'h1:    begin flt_sh = SH_160; flt_lim = LIM_160; end
            3'h2:    begin flt_sh = SH_500; flt_lim = LIM_500; end
            3'h3:    begin flt_sh = SH_1K;  flt_lim = LIM_1K;  end
            default: begin flt_sh = SH_2K;  flt_lim = LIM_2K;  end
        endcase
    end

    always_comb begin
        case (flt_code)
            3'h0:    flt_lim_hi = LIMH_80;
            3'h1:    flt_lim_hi = LIMH_160;
            3'h2:    flt_lim_hi = LIMH_500;
            3'h3:    flt_lim_hi = LIMH_1K;
            default: flt_lim_hi = LIMH_2K;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        fe_range_code <= rng_code;
        fe_tc_lin     <= tc_q;
        fe_tc_quad    <= quadratic_temp_coeff_q;
        case (rng_code)
            3'h0:    fe_range_mt <= 8'h1E;
            3'h4:    fe_range_mt <= 8'h28;
            3'h5:    fe_range_mt <= 8'h3C;
            3'h1:    fe_range_mt <= 8'h4B;
            3'h6:    fe_range_mt <= 8'h50;
            3'h2:    fe_range_mt <= 8'h5A;
            3'h7:    fe_range_mt <= 8'h64;
            default: fe_range_mt <= 8'h96;
        endcase
    end

    // low-pass filter and limited readout
    logic signed [ACC_W-1:0] acc_q, flt_y;
    logic signed [ADC_W-1:0] sample_q, lim_p, lim_h;
    assign flt_y = acc_q >>> flt_sh;
    assign lim_p = $signed(flt_lim);
    assign lim_h = $signed(flt_lim_hi);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_q <= '0;
        end else if (adc_valid) begin
            acc_q <= acc_q - flt_y + ACC_W'(adc_sample);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sample_q <= '0;
        end else if (flt_y > ACC_W'(lim_h)) begin
            sample_q <= lim_h;
        end else if (flt_y < -ACC_W'(lim_p)) begin
            sample_q <= -lim_p;
        end else begin
            sample_q <= ADC_W'(flt_y);
        end
    end

    // multiply, add, saturate, clamp
    logic signed [ADC_W+GAIN_W-1:0] prod_q;
    logic signed [SUM_W-1:0]        sum, top, sat, lo, hi;
    logic [DUTY_W-1:0]              dc_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prod_q <= '0;
        end else begin
            prod_q <= sample_q * gain_q;
        end
    end

    always_comb begin
        sum = SUM_W'(prod_q >>> GAIN_FRC) + (SUM_W'(qd_q) <<< 1);
        top = (qd_q < 0) ? SUM_W'(DUTY_FULL) + (SUM_W'(qd_q) <<< 1)
                         : SUM_W'(DUTY_FULL);
        sat = (sum < 0) ? '0 : ((sum > top) ? top : sum);
        lo  = SUM_W'(floor_q);
        hi  = SUM_W'(ceil_q);
        if (sat < lo) begin
            sat = lo;
        end
        if (sat > hi) begin
            sat = hi;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dc_q <= '0;
        end else begin
            dc_q <= DUTY_W'(sat);
        end
    end

    // pwm step divider and period counter
    logic [15:0]       div_q;
    logic              tick;
    logic [10:0]       cnt_q;
    logic [DUTY_W-1:0] duty_q;
    assign tick = (div_q == 16'(PWM_DIV - 1));

    always_ff @(posedge clk_sys) begin
        if (rst || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || state_q != HPC_RUN) begin
            cnt_q  <= '0;
            duty_q <= dc_q;
        end else if (tick) begin
            cnt_q <= cnt_q + 11'h001;
            if (cnt_q == 11'h7FF) begin
                duty_q <= dc_q;
            end
        end
    end

    // mode control
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= HPC_LOAD;
        end else begin
            case (state_q)
                HPC_LOAD: state_q <= HPC_RUN;
                HPC_RUN:  if (prog_s2_q && !lock_act_q) state_q <= HPC_PROG;
                HPC_PROG: if (!prog_s2_q) state_q <= HPC_LOAD;
                default:  state_q <= HPC_LOAD;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwm_out   <= 1'b0;
            prog_busy <= 1'b0;
        end else begin
            pwm_out   <= (state_q == HPC_RUN) && ({1'b0, cnt_q} < duty_q);
            prog_busy <= (state_q == HPC_PROG);
        end
    end

    // command answers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
        end else begin
            rsp_valid <= cmd_valid && !lock_act_q;
            rsp_data  <= '0;
            if (cmd_valid && !cmd_write) begin
                case (cmd_addr)
                    IX_MODE:  rsp_data <= DATA_W'(mode_q);
                    IX_GAIN:  rsp_data <= DATA_W'($unsigned(gain_q));
                    IX_QD:    rsp_data <= DATA_W'($unsigned(qd_q));
                    IX_FLOOR: rsp_data <= DATA_W'(floor_q);
                    IX_CEIL:  rsp_data <= DATA_W'(ceil_q);
                    IX_TC:    rsp_data <= DATA_W'(tc_q);
                    IX_QUADRATIC_TEMP_COEFF:  rsp_data <= DATA_W'(quadratic_temp_coeff_q);
                    IX_LOCK:  rsp_data <= DATA_W'(nv_lock);
                    IX_SAMP:  rsp_data <= DATA_W'($unsigned(sample_q));
                    IX_TRIMO: rsp_data <= TRIM_OSC;
                    IX_TRIMA: rsp_data <= TRIM_ADC;
                    default:  rsp_data <= '0;
                endcase
            end
        end
    end

    // checks
    a_prog_silent: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == HPC_PROG |=> !pwm_out)
        else $error("pwm active during programming");
    a_lock_ignores: assert property (@(posedge clk_sys) disable iff (rst)
        lock_act_q && cmd_valid |=> !rsp_valid)
        else $error("locked part answered");
    a_lock_sticky: assert property (@(posedge clk_sys) disable iff (nv_clear)
        nv_lock |=> nv_lock)
        else $error("lock bit cleared");
    a_lock_frozen: assert property (@(posedge clk_sys) disable iff (rst)
        lock_act_q |=> $stable(gain_q) && $stable(qd_q))
        else $error("locked register changed");
    a_clamp_range: assert property (
        @(posedge clk_sys) disable iff (rst) ceil_q >= CEIL_W'(floor_q)
        |=> dc_q >= DUTY_W'($past(floor_q))
            && dc_q <= DUTY_W'($past(ceil_q)))
        else $error("duty outside floor and ceiling");
    a_neg_qd_top: assert property (
        @(posedge clk_sys) disable iff (rst)
        qd_q < 0 && $stable(qd_q) |=> $signed({1'b0, dc_q})
            <= $signed({1'b0, DUTY_FULL}) + 2 * $past(qd_q))
        else $error("duty above quiescent plus full scale");
    a_sample_lim: assert property (
        @(posedge clk_sys) disable iff (rst) $stable(flt_code)
        |=> sample_q <= $past(lim_h) && sample_q >= -$past(lim_p))
        else $error("sample beyond corner limit");
    a_write_resp: assert property (
        @(posedge clk_sys) disable iff (rst)
        wr_en && cmd_addr == IX_GAIN |=> gain_q == GAIN_W'($past(cmd_wdata))
            && rsp_valid)
        else $error("write not applied or answered");
    a_load_first: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == HPC_LOAD |=> !pwm_out)
        else $error("pwm before load");
    c_prog_entry: cover property (@(posedge clk_sys) disable iff (rst)
        state_q == HPC_RUN ##1 state_q == HPC_PROG);
    c_floor_hit: cover property (@(posedge clk_sys) disable iff (rst)
        sat == SUM_W'(floor_q) && floor_q != '0);
    c_ceiling_hit: cover property (@(posedge clk_sys) disable iff (rst)
        sum > SUM_W'(ceil_q));
endmodule

// ===== hpc_ctrl_model.sv
// Purpose: programming controller model, supply modulation and telegrams
// Assumes: telegrams are only sent while the supply modulation is raised
// Notes:   all lines change on the falling edge of clk_sys
`timescale 1ns/100ps
module hpc_ctrl_model (
    // clock
    input  wire logic                       clk_sys,
    // supply modulation and decoded telegram
    output logic                            prog_pin,
    output logic                            cmd_valid,
    output logic                            cmd_write,
    output logic [hpc_pkg::ADDR_W-1:0]      cmd_addr,
    output logic [hpc_pkg::DATA_W-1:0]      cmd_wdata,
    // answer and output pin view
    input  wire logic                       rsp_valid,
    input  wire logic [hpc_pkg::DATA_W-1:0] rsp_data,
    input  wire logic                       prog_busy,
    input  wire logic                       pwm_out
);
    import hpc_pkg::*;
    initial begin
        prog_pin  = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr  = 4'hF;
        cmd_wdata = 16'h0000;
    end
    // one telegram inside a modulation burst, answer taken one edge on
    task automatic cmd(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic got,
                       output logic [DATA_W-1:0] rd, output logic busy);
        @(negedge clk_sys);
        prog_pin = 1'b1;
        repeat (5) @(negedge clk_sys);
        busy      = prog_busy & ~pwm_out;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr  = a;
        cmd_wdata = d;
        @(negedge clk_sys);
        got       = rsp_valid;
        rd        = rsp_data;
        cmd_valid = 1'b0;
        cmd_write = ~w;
        cmd_addr  = ~a;
        cmd_wdata = ~d;
        @(negedge clk_sys);
        prog_pin = 1'b0;
    endtask
endmodule

// ===== test_hall_pwm_signal_conditioner.sv
// Purpose: self-checking bench for the pwm signal conditioner
// Assumes: PWM_DIV of 2, one pwm period is 4096 clocks
// Notes:   duty figures are clocks high per period
`timescale 1ns/100ps
module test_hall_pwm_signal_conditioner;
    import hpc_pkg::*;
    logic                    clk_sys;
    logic                    rst;
    logic                    nv_clear;
    logic                    adc_valid;
    logic signed [ADC_W-1:0] adc_sample;
    logic signed [ADC_W-1:0] adc_x;
    logic                    prog_pin;
    logic                    cmd_valid;
    logic                    cmd_write;
    logic [ADDR_W-1:0]       cmd_addr;
    logic [DATA_W-1:0]       cmd_wdata;
    logic                    rsp_valid;
    logic [DATA_W-1:0]       rsp_data;
    logic                    pwm_out;
    logic                    prog_busy;
    logic [FLD_W-1:0]        fe_range_code;
    logic [7:0]              fe_range_mt;
    logic [TC_W-1:0]         fe_tc_lin;
    logic [QUADRATIC_TEMP_COEFF_W-1:0]       fe_tc_quad;
    logic                    got;
    logic                    busy;
    logic [DATA_W-1:0]       rd;
    int                      n_errors;
    int                      comparisons;
    int                      cycles;

    // trim values are arbitrary
    hpc_conditioner #(.TRIM_OSC(16'h1234), .TRIM_ADC(16'h4321),
                      .PWM_DIV(2)) hpc_conditioner_inst (
        .clk_sys(clk_sys), .rst(rst), .nv_clear(nv_clear),
        .adc_valid(adc_valid), .adc_sample(adc_sample),
        .prog_pin(prog_pin), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .pwm_out(pwm_out), .prog_busy(prog_busy),
        .fe_range_code(fe_range_code), .fe_range_mt(fe_range_mt),
        .fe_tc_lin(fe_tc_lin), .fe_tc_quad(fe_tc_quad));
    hpc_ctrl_model hpc_ctrl_model_inst (
        .clk_sys(clk_sys), .prog_pin(prog_pin), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .prog_busy(prog_busy), .pwm_out(pwm_out));

    always #25 clk_sys = ~clk_sys;
    // converter strobes every other clock
    always @(negedge clk_sys) begin
        adc_valid  <= ~adc_valid & ~rst;
        adc_sample <= adc_x;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_errors = n_errors + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic op(input logic w, input logic [3:0] a,
                      input logic [15:0] d);
        hpc_ctrl_model_inst.cmd(w, a, d, got, rd, busy);
    endtask
    task automatic cfg(input logic [15:0] g, q, fl, ce);
        op(1'b1, IX_GAIN, g);
        op(1'b1, IX_QD, q);
        op(1'b1, IX_FLOOR, fl);
        op(1'b1, IX_CEIL, ce);
    endtask
    task automatic meas(input logic [15:0] e);
        int h;
        h = 0;
        repeat (5000) @(negedge clk_sys);
        repeat (4096) begin
            @(negedge clk_sys);
            if (pwm_out === 1'b1) h++;
        end
        chk(16'(h), e);
    endtask

    task automatic t_regs;
        op(1'b1, IX_GAIN, 16'h0800);
        op(1'b0, IX_GAIN, 16'h0000);
        chk({2'h0, rd[13:0]}, 16'h0800);
        op(1'b1, IX_GAIN, 16'h3800);
        op(1'b0, IX_GAIN, 16'h0000);
        chk({2'h0, rd[13:0]}, 16'h3800);
        chk({15'h0, busy}, 16'h0001);
        op(1'b1, IX_TRIMO, 16'h0F0F);
        op(1'b0, IX_TRIMO, 16'h0000);
        chk(rd, 16'h1234);
        op(1'b1, IX_SAMP, 16'h0F0F);
        chk({15'h0, got}, 16'h0001);
        op(1'b1, IX_TC, 16'h002A);
        op(1'b1, IX_QUADRATIC_TEMP_COEFF, 16'h0015);
        chk({10'h0, fe_tc_lin}, 16'h002A);
        chk({11'h0, fe_tc_quad}, 16'h0015);
        op(1'b0, 4'hF, 16'h0000);
        chk(rd, 16'h0000);
    endtask
    task automatic t_range;
        logic [7:0] mt [8] = '{8'h1E, 8'h4B, 8'h5A, 8'h96,
                               8'h28, 8'h3C, 8'h50, 8'h64};
        for (int r = 0; r < 8; r++) begin
            op(1'b1, IX_MODE, 16'h0020 | 16'(r));
            chk({8'h0, fe_range_mt}, {8'h0, mt[r]});
            chk({13'h0, fe_range_code}, 16'(r));
        end
    endtask
    task automatic t_filter;
        logic [15:0] lim [5] = '{16'h0F7F, 16'h07C1, 16'h14AA,
                                 16'h0A55, 16'h05E7};
        adc_x = 14'sd8000;
        for (int f = 0; f < 5; f++) begin
            op(1'b1, IX_MODE, 16'(f) << 3);
            repeat (3000) @(negedge clk_sys);
            op(1'b0, IX_SAMP, 16'h0000);
            chk({2'h0, rd[13:0]}, lim[f]);
        end
        adc_x = -14'sd8000;
        repeat (3000) @(negedge clk_sys);
        op(1'b0, IX_SAMP, 16'h0000);
        chk({2'h0, rd[13:0]}, 16'h3A18);
        adc_x = 14'sd500;
        repeat (1000) @(negedge clk_sys);
        op(1'b0, IX_SAMP, 16'h0000);
        chk({2'h0, rd[13:0]}, 16'h01F4);
    endtask
    task automatic t_duty;
        cfg(16'h0800, 16'h0000, 16'h0000, 16'h07FF);
        meas(16'd1000);
        cfg(16'h0800, 16'h0100, 16'h0000, 16'h07FF);
        meas(16'd2024);
        cfg(16'h0800, 16'h0100, 16'h0000, 16'd600);
        meas(16'd1200);
        cfg(16'h3800, 16'h0000, 16'd900, 16'h07FF);
        meas(16'd1800);
        adc_x = 14'sd1400;
        cfg(16'h1FFF, 16'h0700, 16'h0000, 16'h07FF);
        meas(16'd3072);
    endtask
    task automatic t_lock;
        adc_x = 14'sd500;
        cfg(16'h3800, 16'h0000, 16'd900, 16'h07FF);
        op(1'b1, IX_LOCK, 16'h0001);
        op(1'b0, IX_GAIN, 16'h0000);
        chk({15'h0, got}, 16'h0001);
        @(negedge clk_sys);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        op(1'b1, IX_GAIN, 16'h0800);
        chk({14'h0, got, busy}, 16'h0000);
        meas(16'd1800);
    endtask

    initial begin
        clk_sys     = 1'b0;
        rst         = 1'b1;
        nv_clear    = 1'b1;
        adc_valid   = 1'b0;
        adc_sample  = '0;
        adc_x       = '0;
        n_errors    = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (4) @(negedge clk_sys);
        nv_clear = 1'b0;
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        t_regs();
        t_range();
        t_filter();
        t_duty();
        t_lock();
        report_and_stop();
    end
endmodule
